//--- verilog/eee_np_pkg.sv
// constants for the energy-efficient next-page register pair
// Behaviour
// - Transmit bit 13 is a writable message-page flag that resets to one.
// - Transmit bit 12 is a writable comply-acknowledge flag that resets to zero.
// - Each next page sent carries a toggle bit opposite to the one last exchanged.
// - The first next page carries the inverse of bit 11 of the base codeword.
// - The transmit toggle bit reads back read-only with a reset value of zero.
// - Transmit bits 10:0 are a writable 11-bit code field that resets to one.
// - The host writes the byte offset, receive upper byte at 0x10, data via 0xA0.
// - Receive bit 15 captures the partner's more-pages flag, reset zero.
// - Receive bit 13 captures the partner's message-page flag, reset zero.
// - Receive bit 11 captures the partner's toggle bit, reset zero.
// - Receive bits 10:0 capture the partner's code field, reset zero.
// - Transmit bit 15 is a writable more-pages flag that resets to zero.
package eee_np_pkg;
    localparam int          NUM_PORTS     = 2;
    // host register addresses
    localparam logic [7:0]  SEL_ADDR      = 8'h6E;
    localparam logic [7:0]  OFS_ADDR      = 8'h6F;
    localparam logic [7:0]  DATA_ADDR     = 8'hA0;
    // selector fields
    localparam logic [2:0]  TABLE_EEE     = 3'h1;
    localparam logic [3:0]  PORT_FIRST    = 4'h3;
    localparam logic [3:0]  PORT_LAST     = 4'h4;
    // indirect byte offsets
    localparam logic [7:0]  OFS_TX_HI     = 8'h0E;
    localparam logic [7:0]  OFS_TX_LO     = 8'h0F;
    localparam logic [7:0]  OFS_RX_HI     = 8'h10;
    localparam logic [7:0]  OFS_RX_LO     = 8'h11;
    // codeword bit positions
    localparam int          BIT_MORE      = 15;
    localparam int          BIT_ACK       = 14;
    localparam int          BIT_MSG       = 13;
    localparam int          BIT_COMPLY_ACK_FLAG      = 12;
    localparam int          BIT_TOGGLE    = 11;
    localparam int          CODE_W        = 11;
    // reset values
    localparam logic        MORE_RST      = 1'b0;
    localparam logic        MSG_RST       = 1'b1;
    localparam logic        COMPLY_ACK_FLAG_RST      = 1'b0;
    localparam logic        TOGGLE_RST    = 1'b0;
    localparam logic [10:0] CODE_RST      = 11'h001;
    localparam logic [15:0] RX_RST        = 16'h0000;
    localparam logic [7:0]  SEL_RST       = 8'h00;
    localparam logic [7:0]  OFS_RST       = 8'h00;
endpackage

//--- verilog/np_toggle.sv
// toggle bit tracker for the locally transmitted next pages
`timescale 1ns/1ns
module np_toggle
    import eee_np_pkg::*;
(
    input  wire logic clock_i,
    input  wire logic resetn_i,
    input  wire logic base_done_i,
    input  wire logic base_toggle_i,
    input  wire logic page_sent_i,
    output logic      toggle_o
);
    typedef struct packed {
        logic toggle;
    } state_t;

    state_t s_q;
    state_t s_d;

    always_comb begin
        s_d = s_q;
        // base page wins: a new exchange restarts the sequence
        if (base_done_i) begin
            s_d.toggle = ~base_toggle_i;
        end else if (page_sent_i) begin
            s_d.toggle = ~s_q.toggle;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_q.toggle <= TOGGLE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign toggle_o = s_q.toggle;
endmodule

//--- verilog/np_rx_capture.sv
// capture of the last next page received from the partner
`timescale 1ns/1ns
module np_rx_capture
    import eee_np_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        resetn_i,
    input  wire logic        page_rcvd_i,
    input  wire logic [15:0] rx_word_i,
    output logic      [15:0] rx_word_o
);
    typedef struct packed {
        logic [15:0] word;
    } state_t;

    state_t s_q;
    state_t s_d;

    always_comb begin
        s_d = s_q;
        if (page_rcvd_i) begin
            s_d.word[BIT_MORE]     = rx_word_i[BIT_MORE];
            s_d.word[BIT_ACK]      = rx_word_i[BIT_ACK];
            s_d.word[BIT_MSG]      = rx_word_i[BIT_MSG];
            s_d.word[BIT_COMPLY_ACK_FLAG]     = rx_word_i[BIT_COMPLY_ACK_FLAG];
            s_d.word[BIT_TOGGLE]   = rx_word_i[BIT_TOGGLE];
            s_d.word[CODE_W-1:0]   = rx_word_i[CODE_W-1:0];
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_q.word <= RX_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign rx_word_o = s_q.word;
endmodule

//--- verilog/eee_next_page_regs.sv
// next-page transmit and receive registers behind the indirect byte port
`timescale 1ns/1ns
module eee_next_page_regs
    import eee_np_pkg::*;
(
    input  wire logic                                clock_i,
    input  wire logic                                resetn_i,
    // host byte register port
    input  wire logic [7:0]                          host_addr_i,
    input  wire logic                                host_wr_i,
    input  wire logic                                host_rd_i,
    input  wire logic [7:0]                          host_wdata_i,
    output logic      [7:0]                          host_rdata_o,
    output logic                                     host_rvalid_o,
    // auto-negotiation arbitration, one lane per port
    input  wire logic [eee_np_pkg::NUM_PORTS-1:0]    base_done_i,
    input  wire logic [eee_np_pkg::NUM_PORTS-1:0]    base_toggle_i,
    input  wire logic [eee_np_pkg::NUM_PORTS-1:0]    page_sent_i,
    input  wire logic [eee_np_pkg::NUM_PORTS-1:0]    page_rcvd_i,
    input  wire logic [eee_np_pkg::NUM_PORTS-1:0][15:0] rx_word_i,
    output logic      [eee_np_pkg::NUM_PORTS-1:0][15:0] tx_word_o
);
    import eee_np_pkg::*;

    typedef struct packed {
        logic              more_pages_flag;
        logic              message_page_flag;
        logic              comply_ack_flag;
        logic [CODE_W-1:0] code;
    } tx_fields_t;

    typedef struct packed {
        logic [7:0]                        sel;
        logic [7:0]                        ofs;
        tx_fields_t [NUM_PORTS-1:0]        tx;
        logic [NUM_PORTS-1:0][15:0]        tx_word;
        logic [7:0]                        rdata;
        logic                              rvalid;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic [NUM_PORTS-1:0]       toggle;
    logic [NUM_PORTS-1:0][15:0] rx_word;
    logic [NUM_PORTS-1:0][15:0] tx_view;

    // per-port helpers and the transmit word as software sees it
    genvar g;
    generate
        for (g = 0; g < NUM_PORTS; g++) begin : g_port
            np_toggle u_toggle (
                .clock_i       (clock_i),
                .resetn_i      (resetn_i),
                .base_done_i   (base_done_i[g]),
                .base_toggle_i (base_toggle_i[g]),
                .page_sent_i   (page_sent_i[g]),
                .toggle_o      (toggle[g])
            );

            np_rx_capture u_rx (
                .clock_i     (clock_i),
                .resetn_i    (resetn_i),
                .page_rcvd_i (page_rcvd_i[g]),
                .rx_word_i   (rx_word_i[g]),
                .rx_word_o   (rx_word[g])
            );

            always_comb begin
                tx_view[g]             = 16'h0000;
                tx_view[g][BIT_MORE]   = s_q.tx[g].more_pages_flag;
                tx_view[g][BIT_ACK]    = 1'b0;
                tx_view[g][BIT_MSG]    = s_q.tx[g].message_page_flag;
                tx_view[g][BIT_COMPLY_ACK_FLAG]   = s_q.tx[g].comply_ack_flag;
                tx_view[g][BIT_TOGGLE] = toggle[g];
                tx_view[g][CODE_W-1:0] = s_q.tx[g].code;
            end
        end
    endgenerate

    // selector decode
    logic       sel_table_ok;
    logic       sel_port_ok;
    logic       sel_ok;
    logic [3:0] port_rel;
    logic       port_idx;

    always_comb begin
        sel_table_ok = (s_q.sel[7:5] == TABLE_EEE);
        sel_port_ok  = (s_q.sel[3:0] >= PORT_FIRST) && (s_q.sel[3:0] <= PORT_LAST);
        sel_ok       = sel_table_ok && sel_port_ok;
        port_rel     = s_q.sel[3:0] - PORT_FIRST;
        port_idx     = port_rel[0];
    end

    // indirect byte read mux; unmapped offsets or a bad selector read zero
    logic [7:0] ind_rdata;

    always_comb begin
        ind_rdata = 8'h00;
        if (sel_ok) begin
            case (s_q.ofs)
                OFS_TX_HI: begin
                    ind_rdata = tx_view[port_idx][15:8];
                end
                OFS_TX_LO: begin
                    ind_rdata = tx_view[port_idx][7:0];
                end
                OFS_RX_HI: begin
                    ind_rdata = rx_word[port_idx][15:8];
                end
                OFS_RX_LO: begin
                    ind_rdata = rx_word[port_idx][7:0];
                end
                default: begin
                    ind_rdata = 8'h00;
                end
            endcase
        end
    end

    // host read mux
    logic [7:0] bus_rdata;

    always_comb begin
        case (host_addr_i)
            SEL_ADDR: begin
                bus_rdata = s_q.sel;
            end
            OFS_ADDR: begin
                bus_rdata = s_q.ofs;
            end
            DATA_ADDR: begin
                bus_rdata = ind_rdata;
            end
            default: begin
                bus_rdata = 8'h00;
            end
        endcase
    end

    // next state
    always_comb begin
        s_d        = s_q;
        s_d.rvalid = host_rd_i;
        if (host_rd_i) begin
            s_d.rdata = bus_rdata;
        end

        if (host_wr_i) begin
            case (host_addr_i)
                SEL_ADDR: begin
                    s_d.sel = host_wdata_i;
                end
                OFS_ADDR: begin
                    s_d.ofs = host_wdata_i;
                end
                DATA_ADDR: begin
                    // receive bytes and the toggle bit ignore writes
                    if (sel_ok) begin
                        case (s_q.ofs)
                            OFS_TX_HI: begin
                                s_d.tx[port_idx].more_pages_flag   = host_wdata_i[7];
                                s_d.tx[port_idx].message_page_flag = host_wdata_i[5];
                                s_d.tx[port_idx].comply_ack_flag   = host_wdata_i[4];
                                s_d.tx[port_idx].code[10:8]        = host_wdata_i[2:0];
                            end
                            OFS_TX_LO: begin
                                s_d.tx[port_idx].code[7:0] = host_wdata_i;
                            end
                            default: begin
                                s_d.ofs = s_q.ofs;
                            end
                        endcase
                    end
                end
                default: begin
                    s_d.sel = s_q.sel;
                end
            endcase
        end

        // codeword handed to arbitration lags the fields by one cycle
        s_d.tx_word = tx_view;
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_q.sel    <= SEL_RST;
            s_q.ofs    <= OFS_RST;
            s_q.rdata  <= 8'h00;
            s_q.rvalid <= 1'b0;
            for (int p = 0; p < NUM_PORTS; p++) begin
                s_q.tx[p].more_pages_flag   <= MORE_RST;
                s_q.tx[p].message_page_flag <= MSG_RST;
                s_q.tx[p].comply_ack_flag   <= COMPLY_ACK_FLAG_RST;
                s_q.tx[p].code              <= CODE_RST;
                s_q.tx_word[p]              <= 16'h0000;
            end
        end else begin
            s_q <= s_d;
        end
    end

    assign host_rdata_o  = s_q.rdata;
    assign host_rvalid_o = s_q.rvalid;
    assign tx_word_o     = s_q.tx_word;
endmodule

//--- tb/eee_next_page_regs_monitor.sv
// assertion checker for the next-page register pair
`timescale 1ns/1ns
module eee_next_page_regs_monitor
    import eee_np_pkg::*;
(
    input wire logic                                    clock_i,
    input wire logic                                    resetn_i,
    input wire logic [7:0]                              host_addr_i,
    input wire logic                                    host_wr_i,
    input wire logic                                    host_rd_i,
    input wire logic [7:0]                              host_wdata_i,
    input wire logic [7:0]                              host_rdata_o,
    input wire logic                                    host_rvalid_o,
    input wire logic [eee_np_pkg::NUM_PORTS-1:0]        base_done_i,
    input wire logic [eee_np_pkg::NUM_PORTS-1:0]        base_toggle_i,
    input wire logic [eee_np_pkg::NUM_PORTS-1:0]        page_sent_i,
    input wire logic [eee_np_pkg::NUM_PORTS-1:0]        page_rcvd_i,
    input wire logic [eee_np_pkg::NUM_PORTS-1:0][15:0]  rx_word_i,
    input wire logic [eee_np_pkg::NUM_PORTS-1:0][15:0]  tx_word_o
);
    logic [7:0]  sel_q;
    logic [7:0]  ofs_q;
    logic [15:0] rx_q;
    wire         data_p3 = host_addr_i == DATA_ADDR && sel_q == 8'h23;
    // shadow of selector, offset and port-3 capture, as the host sees them
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sel_q <= SEL_RST;
            ofs_q <= OFS_RST;
            rx_q  <= RX_RST;
        end else begin
            if (host_wr_i && host_addr_i == SEL_ADDR) sel_q <= host_wdata_i;
            if (host_wr_i && host_addr_i == OFS_ADDR) ofs_q <= host_wdata_i;
            if (page_rcvd_i[0]) rx_q <= rx_word_i[0];
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    a_reset_view: assert property ($rose(resetn_i) |=> tx_word_o[0] == 16'h2001)
        else $error("tx reset view wrong");
    a_rvalid_one: assert property (host_rvalid_o == $past(host_rd_i))
        else $error("rvalid timing wrong");
    a_other_zero: assert property (
        host_rd_i && host_addr_i != DATA_ADDR && host_addr_i != SEL_ADDR
        && host_addr_i != OFS_ADDR |=> host_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_bad_table: assert property (
        host_rd_i && host_addr_i == DATA_ADDR && (sel_q[7:5] != TABLE_EEE
        || sel_q[3:0] < PORT_FIRST || sel_q[3:0] > PORT_LAST) |=> host_rdata_o == 8'h00)
        else $error("unselected read not zero");
    a_rx_read: assert property (host_rd_i && data_p3 && ofs_q == OFS_RX_HI
        |=> host_rdata_o == $past(rx_q[15:8]))
        else $error("rx upper byte wrong");
    a_base_inv: assert property (base_done_i[0]
        |-> ##2 tx_word_o[0][11] == !$past(base_toggle_i[0], 2))
        else $error("first toggle not inverted");
    a_sent_flip: assert property (page_sent_i[0] && !base_done_i[0]
        |-> ##2 tx_word_o[0][11] != $past(tx_word_o[0][11]))
        else $error("toggle did not flip");
    a_tx_write: assert property (host_wr_i && data_p3 && ofs_q == OFS_TX_HI
        |-> ##2 tx_word_o[0][15:12] == ($past(host_wdata_i[7:4], 2) & 4'hB))
        else $error("tx upper write wrong");
endmodule

//--- tb/np_link_peer.sv
// link partner stand-in driving the per-port arbitration events
`timescale 1ns/1ns
module np_link_peer
    import eee_np_pkg::*;
(
    input  wire logic                                   clock_i,
    output logic      [eee_np_pkg::NUM_PORTS-1:0]       base_done_o,
    output logic      [eee_np_pkg::NUM_PORTS-1:0]       base_toggle_o,
    output logic      [eee_np_pkg::NUM_PORTS-1:0]       page_sent_o,
    output logic      [eee_np_pkg::NUM_PORTS-1:0]       page_rcvd_o,
    output logic      [eee_np_pkg::NUM_PORTS-1:0][15:0] rx_word_o
);
    initial begin
        base_done_o = '0;
        base_toggle_o = '1;
        page_sent_o = '0;
        page_rcvd_o = '0;
        rx_word_o = '1;
    end
    // k: 0 base page, 1 local page sent, 2 partner page received
    task automatic event_at(input int k, input int p, input logic [15:0] w);
        @(negedge clock_i);
        base_toggle_o[p] = w[11];
        rx_word_o[p] = w;
        base_done_o[p] = k == 0;
        page_sent_o[p] = k == 1;
        page_rcvd_o[p] = k == 2;
        @(negedge clock_i);
        base_done_o[p] = 1'b0;
        page_sent_o[p] = 1'b0;
        page_rcvd_o[p] = 1'b0;
        // released lines must not keep the last value
        rx_word_o[p] = ~w;
        base_toggle_o[p] = ~w[11];
    endtask
endmodule

//--- tb/eee_next_page_regs_tb.sv
// self-checking bench for the next-page register pair
`timescale 1ns/1ns
module eee_next_page_regs_tb;
    import eee_np_pkg::*;
    localparam logic [15:0] BAD [4] = '{16'h430F, 16'h250F, 16'h220F, 16'h2312};
    logic                       clock = 1'b0;
    logic                       resetn = 1'b0;
    logic [7:0]                 addr = 8'h00;
    logic                       wr = 1'b0;
    logic                       rd = 1'b0;
    logic [7:0]                 wdata = 8'h00;
    logic [7:0]                 rdata;
    logic                       rvalid;
    logic                       tog;
    logic [NUM_PORTS-1:0]       bd, bt, ps, pr;
    logic [NUM_PORTS-1:0][15:0] rxw, txw;
    int                         failures = 0;
    int                         compares = 0;
    int                         cycles = 0;
    eee_next_page_regs u_dut (.clock_i(clock), .resetn_i(resetn), .host_addr_i(addr),
        .host_wr_i(wr), .host_rd_i(rd), .host_wdata_i(wdata), .host_rdata_o(rdata),
        .host_rvalid_o(rvalid), .base_done_i(bd), .base_toggle_i(bt), .page_sent_i(ps),
        .page_rcvd_i(pr), .rx_word_i(rxw), .tx_word_o(txw));
    np_link_peer u_peer (.clock_i(clock), .base_done_o(bd), .base_toggle_o(bt),
        .page_sent_o(ps), .page_rcvd_o(pr), .rx_word_o(rxw));
    initial begin
        forever #5 clock = ~clock;
    end
    task automatic give_verdict();
        if (failures == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            give_verdict();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one strobe per call with an idle edge after, so no strobe is set twice at once
    task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        addr = a;
        wdata = d;
        wr = w;
        rd = !w;
        @(negedge clock);
        wr = 1'b0;
        rd = 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        op(1'b0, a, 8'h00);
        chk({7'h00, rvalid, rdata}, {7'h00, 1'b1, exp});
    endtask
    task automatic sel(input logic [7:0] s, input logic [7:0] o);
        op(1'b1, SEL_ADDR, s);
        op(1'b1, OFS_ADDR, o);
    endtask
    initial begin
        repeat (10) @(negedge clock);
        resetn = 1'b1;
        sel(8'h23, OFS_TX_HI);
        rd_chk(DATA_ADDR, 8'h20);
        rd_chk(SEL_ADDR, 8'h23);
        sel(8'h23, OFS_TX_LO);
        rd_chk(DATA_ADDR, 8'h01);
        sel(8'h23, OFS_RX_HI);
        rd_chk(DATA_ADDR, 8'h00);
        sel(8'h23, OFS_TX_HI);
        op(1'b1, DATA_ADDR, 8'hFF);
        rd_chk(DATA_ADDR, 8'hB7);
        op(1'b1, DATA_ADDR, 8'h48);
        rd_chk(DATA_ADDR, 8'h00);
        op(1'b1, OFS_ADDR, OFS_TX_LO);
        op(1'b1, DATA_ADDR, 8'h00);
        rd_chk(DATA_ADDR, 8'h00);
        chk(txw[0], 16'h0000);
        op(1'b1, OFS_ADDR, OFS_TX_HI);
        for (int i = 0; i < 4; i++) begin
            u_peer.event_at(i / 2, 0, {4'h0, !i[0], 11'h000});
            tog = (i < 2) ? i[0] : !tog;
            rd_chk(DATA_ADDR, {4'h0, tog, 3'h0});
        end
        u_peer.event_at(0, 1, 16'h0000);
        sel(8'h24, OFS_TX_HI);
        rd_chk(DATA_ADDR, 8'h28);
        chk(txw[1], 16'h2801);
        chk({15'h0, txw[0][11]}, {15'h0, tog});
        u_peer.event_at(2, 0, 16'hDBCA);
        sel(8'h23, OFS_RX_HI);
        op(1'b1, DATA_ADDR, 8'h00);
        rd_chk(DATA_ADDR, 8'hDB);
        op(1'b1, OFS_ADDR, OFS_RX_LO);
        rd_chk(DATA_ADDR, 8'hCA);
        for (int i = 0; i < 4; i++) begin
            sel(BAD[i][15:8], BAD[i][7:0]);
            op(1'b1, DATA_ADDR, 8'h77);
            rd_chk(DATA_ADDR, 8'h00);
        end
        sel(8'h23, OFS_TX_LO);
        rd_chk(DATA_ADDR, 8'h00);
        // a bad port 2 selector would land its write on port 4
        sel(8'h24, OFS_TX_LO);
        rd_chk(DATA_ADDR, 8'h01);
        rd_chk(8'h55, 8'h00);
        // mid-run reset must restore every written or captured field
        resetn = 1'b0;
        repeat (10) @(negedge clock);
        resetn = 1'b1;
        rd_chk(SEL_ADDR, 8'h00);
        sel(8'h23, OFS_TX_HI);
        rd_chk(DATA_ADDR, 8'h20);
        op(1'b1, OFS_ADDR, OFS_RX_LO);
        rd_chk(DATA_ADDR, 8'h00);
        give_verdict();
    end
endmodule
bind eee_next_page_regs eee_next_page_regs_monitor u_mon (.clock_i(clock_i),
    .resetn_i(resetn_i), .host_addr_i(host_addr_i), .host_wr_i(host_wr_i),
    .host_rd_i(host_rd_i), .host_wdata_i(host_wdata_i), .host_rdata_o(host_rdata_o),
    .host_rvalid_o(host_rvalid_o), .base_done_i(base_done_i), .base_toggle_i(base_toggle_i),
    .page_sent_i(page_sent_i), .page_rcvd_i(page_rcvd_i), .rx_word_i(rx_word_i),
    .tx_word_o(tx_word_o));
